// >>> fscp_map.vh
// Constants for the flash status, configuration and protection block
// Behaviour
// R1: Suspend flag sets on suspend, clears on resume and on power cycle.
// R2: Three security lock bits sit at status bits 13, 12, 11, default 0.
// R3: Each lock bit can be set alone; once set it never clears. The code clears all three to 0 while rst_n is low.
// R4: Quad enable at bit 9: 0 keeps pause pin, 1 enables IO2/IO3.
// R5: Current address width bit reads 0 for 3-byte, 1 for 4-byte.
// R6: Power-up address bit chooses starting address width at power-on or reset.
// R7: Power-up address bit changes only by write enable then status write. The code also resets it to 0 while rst_n is low.
// R8: Scheme bit 0 uses range protect bits; 1 uses individual locks.
// R9: All individual sector and block locks are set at power-on and reset.
// R10: Two-bit drive field: 00 100%, 01 75%, 10 50%, 11 25% default.
// R11: Reserved bits read as zero; writes to them have no effect.
// R12: Level 0 none, 1-9 64KB doubling from top or bottom, high levels all.
// R13: Program or erase touching any protected byte is ignored entirely.
// R14: Complement bit inverts the protected and unprotected ranges.
// R15: Status writes are accepted only while the write latch is set.
// R16: Current width loads from power-up width at every power-on and reset.
// R17: Full range checked before start; rejected commands start no busy cycle.
`ifndef FSCP_MAP_VH
`define FSCP_MAP_VH
`define FSCP_OP_WREN 8'h06
`define FSCP_OP_WRDI 8'h04
`define FSCP_OP_RD2 8'h35
`define FSCP_OP_RD3 8'h15
`define FSCP_OP_WR2 8'h31
`define FSCP_OP_WR3 8'h11
`define FSCP_OP_SUSP 8'h75
`define FSCP_OP_RESM 8'h7A
`define FSCP_OP_EN4B 8'hB7
`define FSCP_OP_EX4B 8'hE9
`define FSCP_S2_SUS 7
`define FSCP_S2_CMP 6
`define FSCP_S2_LB_HI 5
`define FSCP_S2_LB_LO 3
`define FSCP_S2_QE 1
`define FSCP_S3_ADS 0
`define FSCP_S3_ADP 1
`define FSCP_S3_WPS 2
`define FSCP_S3_DRV_HI 6
`define FSCP_S3_DRV_LO 5
`define FSCP_RST_CMP 1'b0
`define FSCP_RST_LB 3'h0
`define FSCP_RST_QE 1'b0
`define FSCP_RST_ADP 1'b0
`define FSCP_RST_WPS 1'b0
`define FSCP_RST_DRV 2'h3
`define FSCP_BLOCK_BYTES 25'h0010000
`endif

// >>> fscp_status_protect.v
// Status registers two and three, SPI access to them, and the range protect decoder
`timescale 1ns/1ps
`default_nettype none
`include "fscp_map.vh"
module fscp_status_protect #(
	parameter ADDR_W = 25
) (
	input wire clk,
	input wire rst_n,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	output reg spi_miso_o_q,
	output reg spi_miso_oe_q,
	input wire soft_reset,
	input wire top_bottom_select,
	input wire [3:0] protect_level,
	input wire indiv_locked,
	input wire op_req,
	input wire [ADDR_W-1:0] op_start_addr,
	input wire [ADDR_W-1:0] op_end_addr,
	output reg op_go_q,
	output reg op_reject_q,
	output reg write_latch_flag_q,
	output reg suspend_flag_q,
	output reg complement_protect_q,
	output reg [2:0] security_lock_bits_q,
	output reg quad_enable_q,
	output reg hold_enable_q,
	output reg current_addr_width_q,
	output reg powerup_addr_width_q,
	output reg protect_scheme_select_q,
	output reg [1:0] output_drive_level_q,
	output reg lock_all_preset_q
);

	// Pin synchronisers; only the second stage is looked at
	wire [2:0] pin_raw = {spi_sclk, spi_cs_n, spi_mosi};
	// Stages start at each pin's idle level so no false edge follows reset
	localparam [2:0] PIN_IDLE = 3'b010;
	wire [2:0] pin_sync;
	reg sclk_p_q, cs_p_q;
	genvar gi;

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			reg meta_q;
			reg sync_q;
			always @(posedge clk) begin
				if (!rst_n) begin
					meta_q <= PIN_IDLE[gi];
					sync_q <= PIN_IDLE[gi];
				end else begin
					meta_q <= pin_raw[gi];
					sync_q <= meta_q;
				end
			end
			assign pin_sync[gi] = sync_q;
		end
	endgenerate

	wire sclk_s = pin_sync[2];
	wire cs_s = pin_sync[1];
	wire mosi_s = pin_sync[0];

	always @(posedge clk) begin
		if (!rst_n) begin
			sclk_p_q <= 1'b0;
			cs_p_q <= 1'b1;
		end else begin
			sclk_p_q <= sclk_s;
			cs_p_q <= cs_s;
		end
	end

	wire sel = ~cs_s;
	wire sclk_rise = sel & sclk_s & ~sclk_p_q;
	wire sclk_fall = sel & ~sclk_s & sclk_p_q;
	wire cs_fall = ~cs_s & cs_p_q;
	wire cs_rise = cs_s & ~cs_p_q;

	// Frame shifter: bit count within byte, saturating byte count
	reg [2:0] bit_cnt_q;
	reg [1:0] byte_cnt_q;
	reg [7:0] rx_q;
	reg [7:0] opcode_q;
	reg [7:0] data_q;
	reg [7:0] tx_q;
	wire [7:0] rx_next = {rx_q[6:0], mosi_s};

	always @(posedge clk) begin
		if (!rst_n || cs_fall) begin
			bit_cnt_q <= 3'h0;
			byte_cnt_q <= 2'h0;
			rx_q <= 8'h00;
			if (!rst_n) begin
				opcode_q <= 8'h00;
				data_q <= 8'h00;
			end
		end else if (sclk_rise) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			rx_q <= rx_next;
			if (bit_cnt_q == 3'h7) begin
				if (byte_cnt_q != 2'h3)
					byte_cnt_q <= byte_cnt_q + 2'h1;
				if (byte_cnt_q == 2'h0)
					opcode_q <= rx_next;
				if (byte_cnt_q == 2'h1)
					data_q <= rx_next;
			end
		end
	end

	// Commands end on a byte boundary or are dropped
	wire one_byte = (byte_cnt_q == 2'h1) && (bit_cnt_q == 3'h0);
	wire two_byte = (byte_cnt_q == 2'h2) && (bit_cnt_q == 3'h0);
	reg cmd_wren, cmd_wrdi, cmd_susp, cmd_resm, cmd_en4b, cmd_ex4b, cmd_wr2, cmd_wr3;

	// Reads and unknown opcodes fall to the default, so deselect changes nothing
	always @* begin
		cmd_wren = 1'b0;
		cmd_wrdi = 1'b0;
		cmd_susp = 1'b0;
		cmd_resm = 1'b0;
		cmd_en4b = 1'b0;
		cmd_ex4b = 1'b0;
		cmd_wr2 = 1'b0;
		cmd_wr3 = 1'b0;
		case (opcode_q)
			`FSCP_OP_WREN: cmd_wren = one_byte;
			`FSCP_OP_WRDI: cmd_wrdi = one_byte;
			`FSCP_OP_SUSP: cmd_susp = one_byte;
			`FSCP_OP_RESM: cmd_resm = one_byte;
			`FSCP_OP_EN4B: cmd_en4b = one_byte;
			`FSCP_OP_EX4B: cmd_ex4b = one_byte;
			`FSCP_OP_WR2: cmd_wr2 = two_byte;
			`FSCP_OP_WR3: cmd_wr3 = two_byte;
			default: cmd_wren = 1'b0;
		endcase
	end

	wire do_wren = cs_rise & cmd_wren;
	wire do_wrdi = cs_rise & cmd_wrdi;
	wire do_susp = cs_rise & cmd_susp;
	wire do_resm = cs_rise & cmd_resm;
	wire do_en4b = cs_rise & cmd_en4b;
	wire do_ex4b = cs_rise & cmd_ex4b;
	// A write cut short of sixteen bits is not an attempt and keeps the latch
	wire wr2_cmd = cs_rise & cmd_wr2;
	wire wr3_cmd = cs_rise & cmd_wr3;
	wire do_wr2 = wr2_cmd & write_latch_flag_q; // R15
	wire do_wr3 = wr3_cmd & write_latch_flag_q; // R15

	// Read-back images; reserved positions read as zero
	reg [7:0] stat2;
	reg [7:0] stat3;

	always @* begin
		stat2 = 8'h00; // R11
		stat2[`FSCP_S2_SUS] = suspend_flag_q;
		stat2[`FSCP_S2_CMP] = complement_protect_q;
		stat2[`FSCP_S2_LB_HI:`FSCP_S2_LB_LO] = security_lock_bits_q;
		stat2[`FSCP_S2_QE] = quad_enable_q;
		stat3 = 8'h00; // R11
		stat3[`FSCP_S3_ADS] = current_addr_width_q; // R5
		stat3[`FSCP_S3_ADP] = powerup_addr_width_q;
		stat3[`FSCP_S3_WPS] = protect_scheme_select_q;
		stat3[`FSCP_S3_DRV_HI:`FSCP_S3_DRV_LO] = output_drive_level_q;
	end

	wire rd2 = (opcode_q == `FSCP_OP_RD2);
	wire rd3 = (opcode_q == `FSCP_OP_RD3);
	wire reading = sel && (byte_cnt_q != 2'h0) && (rd2 || rd3);
	wire [7:0] rd_byte = rd2 ? stat2 : stat3;

	// Data leaves on the falling edge; the byte repeats while selected
	always @(posedge clk) begin
		if (!rst_n || !sel) begin
			tx_q <= 8'h00;
			spi_miso_o_q <= 1'b0;
			spi_miso_oe_q <= 1'b0;
		end else if (sclk_fall && reading) begin
			spi_miso_oe_q <= 1'b1;
			if (bit_cnt_q == 3'h0) begin
				spi_miso_o_q <= rd_byte[7];
				tx_q <= {rd_byte[6:0], 1'b0};
			end else begin
				spi_miso_o_q <= tx_q[7];
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	// Status and configuration state
	wire any_reset = !rst_n || soft_reset;

	always @(posedge clk) begin
		if (!rst_n) begin
			suspend_flag_q <= 1'b0; // R1
			complement_protect_q <= `FSCP_RST_CMP;
			security_lock_bits_q <= `FSCP_RST_LB; // R2
			quad_enable_q <= `FSCP_RST_QE;
			hold_enable_q <= ~`FSCP_RST_QE;
			powerup_addr_width_q <= `FSCP_RST_ADP;
			protect_scheme_select_q <= `FSCP_RST_WPS;
			output_drive_level_q <= `FSCP_RST_DRV; // R10
		end else begin
			hold_enable_q <= ~quad_enable_q; // R4
			if (do_susp)
				suspend_flag_q <= 1'b1; // R1
			else if (do_resm)
				suspend_flag_q <= 1'b0; // R1
			if (do_wr2) begin
				complement_protect_q <= data_q[`FSCP_S2_CMP];
				// Bits only ever add; a zero written leaves a lock in place
				security_lock_bits_q <= security_lock_bits_q |
					data_q[`FSCP_S2_LB_HI:`FSCP_S2_LB_LO]; // R3
				quad_enable_q <= data_q[`FSCP_S2_QE]; // R4
			end
			if (do_wr3) begin
				powerup_addr_width_q <= data_q[`FSCP_S3_ADP]; // R7
				protect_scheme_select_q <= data_q[`FSCP_S3_WPS]; // R8
				output_drive_level_q <=
					data_q[`FSCP_S3_DRV_HI:`FSCP_S3_DRV_LO]; // R10
			end
		end
	end

	// Address width: power-up bit only matters at reset time
	always @(posedge clk) begin
		if (!rst_n)
			current_addr_width_q <= `FSCP_RST_ADP; // R16
		else if (soft_reset)
			current_addr_width_q <= powerup_addr_width_q; // R6 R16
		else if (do_en4b)
			current_addr_width_q <= 1'b1; // R5
		else if (do_ex4b)
			current_addr_width_q <= 1'b0; // R5
	end

	// Individual lock store is told to set every lock
	always @(posedge clk) begin
		if (any_reset)
			lock_all_preset_q <= 1'b1; // R9
		else
			lock_all_preset_q <= 1'b0;
	end

	// Write latch; a status write attempt always drops it
	always @(posedge clk) begin
		if (any_reset)
			write_latch_flag_q <= 1'b0;
		else if (do_wren)
			write_latch_flag_q <= 1'b1; // R15
		else if (do_wrdi || wr2_cmd || wr3_cmd || op_req)
			write_latch_flag_q <= 1'b0; // R15
	end

	// Range decoder
	localparam [ADDR_W-1:0] TOP = {ADDR_W{1'b1}};
	wire [3:0] lvl_m1 = protect_level - 4'h1;
	wire [ADDR_W-1:0] span = `FSCP_BLOCK_BYTES << lvl_m1; // R12
	wire prot_none = (protect_level == 4'h0); // R12
	wire prot_all = protect_level[3] & (protect_level[2] | protect_level[1]); // R12
	reg reg_v;
	reg [ADDR_W-1:0] reg_lo;
	reg [ADDR_W-1:0] reg_hi;

	always @* begin
		reg_v = 1'b1;
		reg_lo = {ADDR_W{1'b0}};
		reg_hi = TOP;
		if (!complement_protect_q) begin
			if (prot_none)
				reg_v = 1'b0; // R12
			else if (!prot_all) begin
				if (top_bottom_select)
					reg_hi = span - 1'b1; // R12
				else
					reg_lo = TOP - span + 1'b1; // R12
			end
		end else begin
			// Everything outside the normal region is protected
			if (prot_all)
				reg_v = 1'b0; // R14
			else if (!prot_none) begin
				if (top_bottom_select)
					reg_lo = span; // R14
				else
					reg_hi = TOP - span; // R14
			end
		end
	end

	wire hit = reg_v && !(op_end_addr < reg_lo || op_start_addr > reg_hi); // R13
	wire refuse = protect_scheme_select_q ? indiv_locked : hit; // R8 R13

	// Verdict one cycle after the request; a refusal starts nothing
	always @(posedge clk) begin
		if (!rst_n) begin
			op_go_q <= 1'b0;
			op_reject_q <= 1'b0;
		end else begin
			op_go_q <= op_req & ~refuse; // R17
			op_reject_q <= op_req & refuse; // R13 R17
		end
	end

endmodule
`default_nettype wire

// >>> fscp_chk.sv
// Checker for the flash status, configuration and protection block
`timescale 1ns/1ps
`default_nettype none
module fscp_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_cs_n,
	input wire logic soft_reset,
	input wire logic [3:0] protect_level,
	input wire logic indiv_locked,
	input wire logic op_req,
	input wire logic op_go_q,
	input wire logic op_reject_q,
	input wire logic suspend_flag_q,
	input wire logic complement_protect_q,
	input wire logic [2:0] security_lock_bits_q,
	input wire logic quad_enable_q,
	input wire logic hold_enable_q,
	input wire logic current_addr_width_q,
	input wire logic powerup_addr_width_q,
	input wire logic protect_scheme_select_q,
	input wire logic lock_all_preset_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_op_answer: assert property (op_req |=> op_go_q != op_reject_q)
		else $error("no single answer to op");
	chk_lock_sticky: assert property (&(~$past(security_lock_bits_q) | security_lock_bits_q))
		else $error("lock bit cleared");
	chk_hold_lag: assert property (hold_enable_q == !$past(quad_enable_q))
		else $error("hold enable wrong");
	chk_width_reload: assert property (soft_reset |=> current_addr_width_q == powerup_addr_width_q)
		else $error("width not reloaded");
	chk_preset_soft: assert property (soft_reset |=> lock_all_preset_q)
		else $error("locks not preset");
	chk_scheme_locks: assert property (op_req && protect_scheme_select_q |=>
		op_reject_q == $past(indiv_locked)) else $error("lock scheme ignored");
	chk_all_level: assert property (op_req && !protect_scheme_select_q &&
		!complement_protect_q && protect_level[3] && protect_level[2:1] != 2'b00 |=> op_reject_q)
		else $error("full protect missed");
	// Effects land a few cycles after cs_n rises, so an idle link freezes the flag
	chk_sus_idle: assert property (spi_cs_n [*6] |-> $stable(suspend_flag_q))
		else $error("suspend flag moved");
	cover property (op_req ##1 op_reject_q);
	cover property (soft_reset);
	cover property ($rose(suspend_flag_q));
endmodule
bind fscp_status_protect fscp_chk fscp_chk_inst (.clk, .rst_n, .spi_cs_n, .soft_reset,
	.protect_level, .indiv_locked, .op_req, .op_go_q, .op_reject_q, .suspend_flag_q,
	.complement_protect_q, .security_lock_bits_q, .quad_enable_q, .hold_enable_q,
	.current_addr_width_q, .powerup_addr_width_q, .protect_scheme_select_q, .lock_all_preset_q);
`default_nettype wire

// >>> fscp_host.sv
// SPI host model sending status frames, mode 0, MSB first
`timescale 1ns/1ps
`default_nettype none
module fscp_host (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end
	// Clock stands still between frames; whole bytes only, as writes demand
	task automatic frame(input int n, input logic [15:0] d, output logic [7:0] r);
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			mosi = d[i];
			#160 sclk = 1'b1;
			r = {r[6:0], miso};
			#160 sclk = 1'b0;
		end
		#160 cs_n = 1'b1;
		mosi = ~mosi;
		#800;
	endtask
endmodule
`default_nettype wire

// >>> tb_flash_status_config_protect.sv
// Self-checking bench for the flash status, configuration and protection block
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_config_protect;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic soft_reset = 1'b0;
	logic top_bottom_select = 1'b0;
	logic indiv_locked = 1'b0;
	logic op_req = 1'b0;
	logic [3:0] protect_level = 4'h0;
	logic [24:0] op_start_addr = 25'h0000000;
	logic [24:0] op_end_addr = 25'h0000000;
	logic [7:0] r;
	int d;
	wire spi_sclk, spi_cs_n, spi_mosi, spi_miso_o_q, spi_miso_oe_q, op_go_q, op_reject_q;
	wire write_latch_flag_q, suspend_flag_q, complement_protect_q, quad_enable_q, hold_enable_q;
	wire current_addr_width_q, powerup_addr_width_q, protect_scheme_select_q, lock_all_preset_q;
	wire [2:0] security_lock_bits_q;
	wire [1:0] output_drive_level_q;
	int failures = 0;
	int samples_checked = 0;
	int m_sus = 0, m_cmp = 0, m_lb = 0, m_qe = 0, m_ads = 0, m_adp = 0, m_wps = 0, m_drv = 3;
	always #20 clk = ~clk;
	fscp_host fscp_host_inst (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi),
		.miso(spi_miso_oe_q ? spi_miso_o_q : ~spi_miso_o_q));
	fscp_status_protect fscp_status_protect_inst (.clk, .rst_n, .spi_sclk, .spi_cs_n, .spi_mosi,
		.spi_miso_o_q, .spi_miso_oe_q, .soft_reset, .top_bottom_select, .protect_level,
		.indiv_locked, .op_req, .op_start_addr, .op_end_addr, .op_go_q, .op_reject_q,
		.write_latch_flag_q, .suspend_flag_q, .complement_protect_q, .security_lock_bits_q,
		.quad_enable_q, .hold_enable_q, .current_addr_width_q, .powerup_addr_width_q,
		.protect_scheme_select_q, .output_drive_level_q, .lock_all_preset_q);
	task automatic results;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Frames start just after an edge so no pin moves on the sampling edge
	task automatic xf(input int n, input logic [15:0] v);
		@(posedge clk) #1;
		fscp_host_inst.frame(n, v, r);
	endtask
	task automatic wr(input logic [15:0] v);
		xf(8, 16'h0006);
		xf(16, v);
	endtask
	task automatic rd;
		logic [7:0] e2, e3;
		e2 = {m_sus[0], m_cmp[0], m_lb[2:0], 1'b0, m_qe[0], 1'b0};
		e3 = {1'b0, m_drv[1:0], 2'b00, m_wps[0], m_adp[0], m_ads[0]};
		xf(16, 16'h3500);
		chk(r, e2);
		xf(16, 16'h1500);
		chk(r, e3);
		chk({6'h00, spi_miso_oe_q, write_latch_flag_q}, 8'h00);
		chk({suspend_flag_q, complement_protect_q, security_lock_bits_q, 1'b0,
			quad_enable_q, hold_enable_q}, {e2[7:1], !m_qe[0]});
		chk({1'b0, output_drive_level_q, 2'b00, protect_scheme_select_q,
			powerup_addr_width_q, current_addr_width_q}, e3);
	endtask
	task automatic op(input int s, input int e);
		int sz, lo, rx;
		sz = protect_level == 0 ? 0 : protect_level > 9 ? 32'h2000000 :
			32'h10000 << (protect_level - 1);
		lo = top_bottom_select ? 0 : 32'h2000000 - sz;
		if (m_wps != 0)
			rx = indiv_locked;
		else if (m_cmp != 0)
			rx = !(sz > 0 && s >= lo && e < lo + sz);
		else
			rx = sz > 0 && s < lo + sz && e >= lo;
		@(posedge clk) #1;
		op_req = 1'b1;
		op_start_addr = s[24:0];
		op_end_addr = e[24:0];
		@(posedge clk) #1;
		op_req = 1'b0;
		chk({6'h00, op_go_q, op_reject_q}, {6'h00, rx == 0, rx != 0});
	endtask
	// Two ops in three hug block edges on either side, where an off-by-one would show; every third is a random span
	task automatic sweep;
		int s, e;
		for (int i = 0; i < 200; i++) begin
			{protect_level, top_bottom_select, indiv_locked} = 6'($urandom);
			s = (32'h10000 << ($urandom % 9)) - $urandom % 2;
			if (i % 3 == 1)
				s = 32'h1FFFFFF - s;
			e = s;
			if (i % 3 == 2) begin
				s = $urandom % 32'h1FC0000;
				e = s + $urandom % 32'h40000;
			end
			op(s, e);
		end
	endtask
	initial begin
		#1000000;
		failures++;
		results;
	end
	initial begin
		void'($urandom(32'hBCA6));
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		rd;
		sweep;
		d = $urandom | 32'h40;
		xf(16, {8'h31, d[7:0]});
		rd;
		xf(8, 16'h0006);
		chk({7'h00, write_latch_flag_q}, 8'h01);
		xf(16, {8'h31, d[7:0]});
		m_cmp = 1;
		m_lb = d[5:3];
		m_qe = d[1];
		rd;
		sweep;
		wr(16'h3100);
		m_cmp = 0;
		m_qe = 0;
		rd;
		d = $urandom | 32'h06;
		wr({8'h11, d[7:0]});
		m_drv = d[6:5];
		m_wps = 1;
		m_adp = 1;
		rd;
		xf(8, 16'h0075);
		xf(8, 16'h00B7);
		m_sus = 1;
		m_ads = 1;
		rd;
		xf(8, 16'h007A);
		xf(8, 16'h00E9);
		m_sus = 0;
		m_ads = 0;
		rd;
		@(posedge clk) #1 soft_reset = 1'b1;
		@(posedge clk) #1 soft_reset = 1'b0;
		chk({7'h00, lock_all_preset_q}, 8'h01);
		@(posedge clk) #1;
		chk({7'h00, lock_all_preset_q}, 8'h00);
		m_ads = m_adp;
		rd;
		sweep;
		results;
	end
endmodule
`default_nettype wire
